//--- include/vbrd_pkg.sv
// Package for the video buffer register read controller
`default_nettype none
package vbrd_pkg;
   // Fixed upper five bits of the target address
   localparam logic [4:0] ADDR_FIXED = 5'h0b;
   // Direction bits
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   // Channel subaddress codes and upper-bit pad
   localparam logic [1:0] CHAN_FIRST = 2'h1;
   localparam logic [1:0] CHAN_LAST = 2'h3;
   localparam logic [5:0] SUB_PAD = 6'h00;
   // Bus timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_CYC = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // Request from the user
   typedef struct packed {
      logic [1:0] chan;
      logic [1:0] strap;
   } vbrd_req_t;

   // Result to the user
   typedef struct packed {
      logic [7:0] data;
      logic nack;
   } vbrd_rsp_t;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_BYTE, ST_STOP, ST_GAP, ST_DONE
   } vbrd_state_t;
endpackage : vbrd_pkg
`default_nettype wire

//--- logic/vbrd_host.sv
// Controller that reads one channel register of the video buffer over the serial bus
`default_nettype none
module vbrd_host #(
   parameter int QUARTER = vbrd_pkg::QUARTER_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // User request
   input wire logic req_valid_i,
   input wire vbrd_pkg::vbrd_req_t req_i,
   output logic req_ready_o,
   // User answer
   output logic rsp_valid_o,
   output vbrd_pkg::vbrd_rsp_t rsp_o,
   // Bus clock pin
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   // Bus data pin
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   initial begin
      if (QUARTER < 1) begin
         $error("QUARTER must be at least one");
      end
   end

   localparam int QW = $clog2(QUARTER + 1);

   // Counter must reach the last quarter count
   initial begin
      if ((QUARTER - 1) >= (1 << QW)) begin
         $error("QUARTER does not fit its counter");
      end
   end

   // Bit timing, all counted in quarters of QUARTER clocks:
   //   quarter 0 - data set up while the clock line is held low
   //   quarter 1 - clock line let go, pull-up raises it
   //   quarter 2 - data line sampled in the middle of clock high
   //   quarter 3 - clock line pulled low again, bit index moves on
   // Start pulls data low under a high clock, then pulls the clock.
   // Stop pulls data, lets the clock go, then lets the data go.
   // A bus-free gap of one bit time follows every stop.
   // Limitation: the clock line is never read back, so a target
   // that stretches the clock will be sampled too early.
   // Byte counter: 0 write address, 1 subaddress, 2 read address,
   // 3 data byte from the target.

   vbrd_pkg::vbrd_state_t st_q, st_d;
   logic [QW-1:0] qcnt_q, qcnt_d;
   logic [1:0] ph_q, ph_d;         // Quarter phase within a bit
   logic [3:0] bit_q, bit_d;       // Bit index, 8 is the acknowledge slot
   logic [1:0] byte_q, byte_d;     // 0 addr-w, 1 sub, 2 addr-r, 3 data
   logic [7:0] sh_q, sh_d;
   logic [7:0] rx_q, rx_d;
   logic nack_q, nack_d;
   vbrd_pkg::vbrd_req_t rq_q, rq_d;
   logic sdal_q, sdal_d;           // Data line pulled low when set
   logic scll_q, scll_d;           // Clock line pulled low when set
   logic rdy_q, rdy_d, vld_q, vld_d;
   vbrd_pkg::vbrd_rsp_t rsp_q, rsp_d; // Result held between reads
   logic tick;

   // Address byte for a phase
   // fixed pattern plus straps
   function automatic logic [7:0] addr_byte(input logic [1:0] strap, input logic dir);
      addr_byte = {vbrd_pkg::ADDR_FIXED, strap, dir};
   endfunction : addr_byte

   assign tick = (qcnt_q == QW'(QUARTER - 1));

   // Next-state sequencing
   always_comb begin
      st_d = st_q;
      qcnt_d = tick ? '0 : qcnt_q + QW'(1);
      ph_d = ph_q;
      bit_d = bit_q;
      byte_d = byte_q;
      sh_d = sh_q;
      rx_d = rx_q;
      nack_d = nack_q;
      rq_d = rq_q;
      sdal_d = sdal_q;
      scll_d = scll_q;
      rdy_d = rdy_q;
      vld_d = 1'b0;
      case (st_q)
         vbrd_pkg::ST_IDLE: begin
            qcnt_d = '0;
            scll_d = 1'b0;
            sdal_d = 1'b0;
            if (req_valid_i && rdy_q) begin
               rdy_d = 1'b0;
               rq_d = req_i;
               byte_d = 2'h0;
               nack_d = 1'b0;
               ph_d = 2'h0;
               st_d = vbrd_pkg::ST_START;
            end
         end
         vbrd_pkg::ST_START: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h0) begin
                  sdal_d = 1'b1;
               end else if (ph_q == 2'h2) begin
                  scll_d = 1'b1;
                  ph_d = 2'h0;
                  bit_d = '0;
                  sh_d = addr_byte(rq_q.strap, byte_q[1] ? vbrd_pkg::DIR_READ
                                                         : vbrd_pkg::DIR_WRITE);
                  st_d = vbrd_pkg::ST_BYTE;
               end
            end
         end
         vbrd_pkg::ST_BYTE: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               case (ph_q)
                  2'h0: begin
                     // Drive data while clock is low
                     if (bit_q == vbrd_pkg::ACK_SLOT) begin
                        // not-acknowledge after the data byte
                        // Released in every slot: target acks, or our NACK
                        sdal_d = 1'b0;
                     end else if (byte_q == 2'h3) begin
                        sdal_d = 1'b0;   // Release for target data
                     end else begin
                        sdal_d = ~sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                     end
                  end
                  2'h1: scll_d = 1'b0;
                  2'h2: begin
                     // Sample in mid high; a held-low clock is not stretched here
                     if (bit_q == vbrd_pkg::ACK_SLOT) begin
                        if (byte_q != 2'h3 && sda_i) begin
                           nack_d = 1'b1;
                        end
                     end else if (byte_q == 2'h3) begin
                        rx_d = {rx_q[6:0], sda_i};
                     end
                  end
                  default: begin
                     scll_d = 1'b1;
                     if (bit_q == vbrd_pkg::ACK_SLOT) begin
                        bit_d = '0;
                        if (nack_q || byte_q == 2'h1 || byte_q == 2'h3) begin
                           st_d = vbrd_pkg::ST_STOP;
                        end else if (byte_q == 2'h0) begin
                           byte_d = 2'h1;
                           sh_d = {vbrd_pkg::SUB_PAD, rq_q.chan};
                        end else begin
                           byte_d = 2'h3;
                        end
                     end else begin
                        bit_d = bit_q + 4'h1;
                     end
                  end
               endcase
            end
         end
         vbrd_pkg::ST_STOP: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h0) begin
                  sdal_d = 1'b1;
               end else if (ph_q == 2'h1) begin
                  scll_d = 1'b0;
               end else if (ph_q == 2'h2) begin
                  sdal_d = 1'b0;
                  ph_d = 2'h0;
                  st_d = vbrd_pkg::ST_GAP;
               end
            end
         end
         vbrd_pkg::ST_GAP: begin
            // Bus free time before the next start
            if (tick) begin
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h3) begin
                  ph_d = 2'h0;
                  if (byte_q == 2'h1 && !nack_q) begin
                     byte_d = 2'h2;
                     st_d = vbrd_pkg::ST_START;
                  end else begin
                     st_d = vbrd_pkg::ST_DONE;
                  end
               end
            end
         end
         vbrd_pkg::ST_DONE: begin
            vld_d = 1'b1;
            rdy_d = 1'b1;
            st_d = vbrd_pkg::ST_IDLE;
         end
         default: st_d = vbrd_pkg::ST_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= vbrd_pkg::ST_IDLE;
         qcnt_q <= '0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         nack_q <= 1'b0;
         rq_q <= '0;
         sdal_q <= 1'b0;
         scll_q <= 1'b0;
         rdy_q <= 1'b1;
         vld_q <= 1'b0;
      end else begin
         st_q <= st_d;
         qcnt_q <= qcnt_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         nack_q <= nack_d;
         rq_q <= rq_d;
         sdal_q <= sdal_d;
         scll_q <= scll_d;
         rdy_q <= rdy_d;
         vld_q <= vld_d;
      end
   end

   // Result register, loaded once per finished sequence
   // Kept apart from the shifter so rsp_o stays steady while a read runs
   always_comb begin
      rsp_d = rsp_q;
      // result taken when the sequence ends
      if (st_q == vbrd_pkg::ST_DONE) begin
         rsp_d.data = rx_q;
         rsp_d.nack = nack_q;
      end
   end

   // Result flip-flops
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // Open-drain pins: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scll_q;
   assign sda_oe_o = sdal_q;
   assign req_ready_o = rdy_q;
   assign rsp_valid_o = vld_q;
   assign rsp_o = rsp_q;
endmodule : vbrd_host
`default_nettype wire

//--- tb/vbrd_host_assertions.sv
// Port assertions for the register read controller
`default_nettype none
module vbrd_host_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // User side
   input wire logic req_valid_i,
   input wire vbrd_pkg::vbrd_req_t req_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire vbrd_pkg::vbrd_rsp_t rsp_o,
   // Bus pins
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Handshake, result and pin relations
   property p_take; req_valid_i && req_ready_o |=> !req_ready_o; endproperty
   property p_rise; $rose(req_ready_o) |-> rsp_valid_o; endproperty
   property p_pulse; rsp_valid_o |=> !rsp_valid_o; endproperty
   property p_bound; $fell(req_ready_o) |-> ##[1:1000] rsp_valid_o; endproperty
   property p_hold; !rsp_valid_o |-> $stable(rsp_o); endproperty
   property p_idle; req_ready_o |-> !scl_oe_o && !sda_oe_o; endproperty
   property p_drain; !scl_o && !sda_o; endproperty
   property p_start; $rose(sda_oe_o) && !scl_oe_o |-> !req_ready_o; endproperty
   property p_end; rsp_valid_o |-> $past(!req_ready_o); endproperty
   a_take: assert property (p_take) else $error("request not taken");
   a_rise: assert property (p_rise) else $error("ready without result");
   a_pulse: assert property (p_pulse) else $error("result pulse too long");
   a_bound: assert property (p_bound) else $error("read never finished");
   a_hold: assert property (p_hold) else $error("result changed alone");
   a_idle: assert property (p_idle) else $error("lines held when idle");
   a_drain: assert property (p_drain) else $error("pin driven high");
   a_start: assert property (p_start) else $error("start while idle");
   a_end: assert property (p_end) else $error("result without read");
   // Main scenarios
   c_read: cover property (rsp_valid_o && !rsp_o.nack);
   c_nack: cover property (rsp_valid_o && rsp_o.nack);
   c_busy: cover property (req_valid_i && !req_ready_o);
endmodule : vbrd_host_chk
bind vbrd_host vbrd_host_chk chk_u (.clk_i, .rst_b_i, .req_valid_i, .req_i, .req_ready_o,
   .rsp_valid_o, .rsp_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o);
`default_nettype wire

//--- tb/vbrd_target_model.sv
// Behavioural video buffer target on the serial bus
`default_nettype none
module vbrd_target_model #(
   parameter logic [1:0] STRAP = 2'h2
) (
   // Bus wires
   input wire logic scl_i,
   input wire logic sda_i,
   output logic pull_o,
   // Register contents and observations
   input wire logic [23:0] regs_i,
   output logic [7:0] wadr_o,
   output logic [7:0] sub_o,
   output logic [7:0] radr_o,
   output logic nack_o,
   output logic [7:0] starts_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] b;
   logic [1:0] sel_q;
   task automatic rx();
      repeat (8) begin
         @(posedge scl_i);
         b = {b[6:0], sda_i};
      end
   endtask : rx
   // One transaction per start; only pulls low, pull-up does the rest
   initial begin
      pull_o = 1'b0;
      starts_o = 8'h00;
      forever begin
         @(negedge sda_i iff scl_i === 1'b1);
         starts_o++;
         rx();
         if (b[7:1] == {vbrd_pkg::ADDR_FIXED, STRAP}) begin
            @(negedge scl_i);
            pull_o = 1'b1;
            if (b[0] == vbrd_pkg::DIR_WRITE) begin
               wadr_o = b;
               @(negedge scl_i);
               pull_o = 1'b0;
               rx();
               sub_o = b;
               sel_q = b[1:0];
               @(negedge scl_i);
               pull_o = 1'b1;
               @(negedge scl_i);
               pull_o = 1'b0;
            end else begin
               radr_o = b;
               for (int i = 7; i >= 0; i--) begin
                  @(negedge scl_i);
                  pull_o = !regs_i[8 * (sel_q - 1) + i];
               end
               @(negedge scl_i);
               pull_o = 1'b0;
               @(posedge scl_i);
               nack_o = sda_i;
            end
         end
      end
   end
endmodule : vbrd_target_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the register read controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] STRAP = 2'h2;
   localparam logic [23:0] REGS = 24'h813ca5;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic vld = 1'b0;
   vbrd_pkg::vbrd_req_t req = '0;
   vbrd_pkg::vbrd_rsp_t rsp;
   logic rdy, rsp_v, scl_oe, sda_oe, pull, nk;
   logic [7:0] wadr, sub, radr, starts;
   int miscompares = 0;
   int n_checks = 0;
   // Open-drain wires with pull-ups
   wire scl = !scl_oe;
   wire sda = !(sda_oe || pull);
   always #5 clk_i = ~clk_i;
   vbrd_host #(.QUARTER(2)) dut_u (.clk_i, .rst_b_i, .req_valid_i(vld), .req_i(req),
      .req_ready_o(rdy), .rsp_valid_o(rsp_v), .rsp_o(rsp), .scl_i(scl), .scl_o(),
      .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
   vbrd_target_model #(.STRAP(STRAP)) tgt_u (.scl_i(scl), .sda_i(sda), .pull_o(pull),
      .regs_i(REGS), .wadr_o(wadr), .sub_o(sub), .radr_o(radr), .nack_o(nk), .starts_o(starts));
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One read; chan changes after take, hold keeps asking while busy
   task automatic rd(input logic [1:0] c, input logic [1:0] s, input logic hold);
      int n;
      logic [7:0] st;
      logic hit;
      n = 0;
      st = starts;
      hit = (s == STRAP);
      req.chan = c;
      req.strap = s;
      vld = 1'b1;
      @(negedge clk_i);
      vld = hold;
      req.chan = c + 2'h1;
      while (rsp_v !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      vld = 1'b0;
      chk("done", n < 2000, 1'b1);
      chk("ready", rdy, 1'b1);
      chk("nack", rsp.nack, !hit);
      chk("starts", starts - st, hit ? 9'h2 : 9'h1);
      if (hit) begin
         chk("data", rsp.data, REGS[8 * (c - 1) +: 8]);
         chk("wadr", wadr, {vbrd_pkg::ADDR_FIXED, s, vbrd_pkg::DIR_WRITE});
         chk("sub", sub, {vbrd_pkg::SUB_PAD, c});
         chk("radr", radr, {vbrd_pkg::ADDR_FIXED, s, vbrd_pkg::DIR_READ});
         chk("mnack", nk, 1'b1);
      end
   endtask : rd
   // Every channel back to back, one full sequence each
   task automatic t_channels();
      for (int c = 1; c <= 3; c++) rd(2'(c), STRAP, 1'b0);
   endtask : t_channels
   // Wrong strap refused, then a good read recovers
   task automatic t_bad_strap();
      rd(2'h2, ~STRAP, 1'b0);
      rd(2'h2, STRAP, 1'b0);
   endtask : t_bad_strap
   // Request held while busy must be ignored
   task automatic t_refused();
      rd(2'h3, STRAP, 1'b1);
      rd(2'h1, STRAP, 1'b0);
   endtask : t_refused
   // Main sequence, inputs move on the falling edge
   initial begin
      repeat (8) @(negedge clk_i);
      rst_b_i = 1'b1;
      @(negedge clk_i);
      t_channels();
      t_bad_strap();
      t_refused();
      conclude();
   end
   // Watchdog: seven reads need about 2,100 cycles
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
